// ===== hw/ari_round_unit.sv
// ari_round_unit: executes one cipher round per issued decrypt or middle encrypt instruction, one cycle later
// assumes the core supplies operands and memory checks in the issue cycle
`timescale 1ns/1ns

// Overview of operation
// - opcode 66 0F 38 DE is a middle decrypt, DF a last decrypt round
// - opcode 66 0F 38 DC is a middle encrypt, DD a last encrypt round; DD here is computed but flagged not implemented, destination unwritten
// - middle decrypt: inverse shift, inverse substitute, inverse mix, then key xor
// - last decrypt: inverse shift, inverse substitute, no mixing, then key xor
// - middle encrypt: shift, substitute, mix columns, then key xor
// - only the low 128 destination bits change; upper bits kept
// - state comes from destination; key from a register or memory
// - protected mode: illegal data segment address gives protection fault, code 0
// - any mode: memory operand off a 16-byte boundary gives protection fault
// - protected mode: illegal stack segment address gives stack fault, code 0
// - task switched flag set gives device not available fault
// - emulation flag set or extended state support clear gives invalid opcode
// - cipher feature clear or bus lock prefix gives invalid opcode
// - real mode: operand reaching past FFFFH gives protection fault
// - virtual-8086 mode: real mode faults plus page faults
// - compatibility mode checks exactly as protected mode
// - 64-bit mode: non-canonical stack address stack fault, others protection fault
// - inverse shift rotates rows one to three right by that many bytes
// - substitution indexes a 16x16 table by upper and lower nibble
module ari_round_unit
  import ari_pkg::*;
(
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rst,
  // instruction issue
  input  wire logic         issueValid,
  input  wire logic [31:0]  opBytes,
  input  wire logic [7:0]   modrm,
  input  wire logic         lockPrefix,
  // mode and control words
  input  wire ari_mode_t    cpuMode,
  input  wire logic [31:0]  cr0Word,
  input  wire logic [31:0]  cr4Word,
  input  wire logic [31:0]  featWord,
  // memory operand fetch
  input  wire logic [63:0]  effAddr,
  input  wire logic         stackSeg,
  input  wire logic         segIllegal,
  input  wire logic         pageFault,
  input  wire logic [31:0]  pageFaultCode,
  input  wire logic [127:0] memKey,
  // register operands
  input  wire logic [255:0] dstVec,
  input  wire logic [127:0] srcKey,
  // completion
  output logic              roundDone_q,
  output logic              destWrite_q,
  output logic [255:0]      destValue_q,
  output logic              notImpl_q,
  // fault report
  output logic              faultValid_q,
  output ari_fault_t        faultKind_q,
  output logic [31:0]       faultCode_q
);

  logic       isRound;
  logic       isEnc;
  logic       isLast;
  logic       isEncLast;
  logic       memOperand;
  logic       flagsOk;
  ari_fault_t chkKind;
  logic       addrNonCanon;

  logic [127:0] roundKey;
  logic [127:0] stateIn;
  logic [127:0] shifted;
  logic [127:0] subbed;
  logic [127:0] mixed;
  logic [127:0] roundOut;

  function automatic logic [7:0] xtime(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
  endfunction

  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [3:0] c);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 4; i++) begin
      if (c[i]) begin
        p = p ^ x;
      end
      x = xtime(x);
    end
    return p;
  endfunction

  // rows are bytes 4c+r; forward rotates left, inverse right
  function automatic logic [127:0] shiftRows(input logic [127:0] s, input logic inv);
    logic [127:0] o;
    int           src;
    o = 128'h0;
    for (int r = 0; r < 4; r++) begin
      for (int c = 0; c < 4; c++) begin
        src = inv ? ((c - r + 4) % 4) : ((c + r) % 4);
        o[8*(4*c+r) +: 8] = s[8*(4*src+r) +: 8];
      end
    end
    return o;
  endfunction

  // circulant matrix: row i weights byte k by coef[(k-i) mod 4]
  function automatic logic [127:0] mixColumns(input logic [127:0] s, input logic inv);
    logic [127:0] o;
    logic [15:0]  coef;
    logic [7:0]   acc;
    o    = 128'h0;
    coef = inv ? 16'hEBD9 : 16'h2311;
    for (int c = 0; c < 4; c++) begin
      for (int i = 0; i < 4; i++) begin
        acc = 8'h00;
        for (int k = 0; k < 4; k++) begin
          acc = acc ^ gmul(s[8*(4*c+k) +: 8], coef[4*(3-((k-i+4)%4)) +: 4]);
        end
        o[8*(4*c+i) +: 8] = acc;
      end
    end
    return o;
  endfunction

  // decode: fixed three leading bytes, last byte picks the round kind
  always_comb begin
    isRound = 1'b0;
    isEnc   = 1'b0;
    isLast  = 1'b0;
    if (opBytes[31:8] == {OPC_PREFIX, OPC_ESCAPE, OPC_MAP}) begin
      unique case (opBytes[7:0])
        OPC_DEC: begin
          isRound = 1'b1;
        end
        OPC_DECLAST: begin
          isRound = 1'b1;
          isLast  = 1'b1;
        end
        OPC_ENC: begin
          isRound = 1'b1;
          isEnc   = 1'b1;
        end
        OPC_ENCLAST: begin
          isRound = 1'b1;
          isEnc   = 1'b1;
          isLast  = 1'b1;
        end
        default: isRound = 1'b0;
      endcase
    end
  end

  assign isEncLast  = isEnc && isLast;
  assign memOperand = modrm[7:6] != MODRM_REG;
  assign flagsOk    = !cr0Word[EMUL_BIT] && cr4Word[XSUP_BIT] && featWord[CIPHER_BIT]
                      && !lockPrefix && !cr0Word[TSW_BIT];
  // own copy of the canonical test, so the checks below need not reach into the checker
  assign addrNonCanon = effAddr[63:CANON_MSB] != {(64 - CANON_MSB){effAddr[CANON_MSB]}};

  // operands: state is the low half of the destination
  assign stateIn  = dstVec[127:0];
  assign roundKey = memOperand ? memKey : srcKey;

  assign shifted = shiftRows(stateIn, !isEnc);

  ari_sub_bytes uSub (
    .stateIn  (shifted),
    .inverse  (!isEnc),
    .stateOut (subbed)
  );

  assign mixed = mixColumns(subbed, !isEnc);

  // last decrypt skips the mix step entirely
  assign roundOut = (isLast ? subbed : mixed) ^ roundKey;

  ari_fault_check uFault (
    .cpuMode    (cpuMode),
    .cr0Word    (cr0Word),
    .cr4Word    (cr4Word),
    .featWord   (featWord),
    .lockPrefix (lockPrefix),
    .memOperand (memOperand),
    .effAddr    (effAddr),
    .stackSeg   (stackSeg),
    .segIllegal (segIllegal),
    .pageFault  (pageFault),
    .faultKind  (chkKind)
  );

  // completion pulse for every decoded round, faulted or not
  always_ff @(posedge mclk) begin
    if (rst) begin
      roundDone_q <= 1'b0;
    end else begin
      roundDone_q <= issueValid && isRound;
    end
  end

  // the last encrypt result is computed but never written: it completes unwritten, and is flagged when no fault is raised
  always_ff @(posedge mclk) begin
    if (rst) begin
      destWrite_q <= 1'b0;
      notImpl_q   <= 1'b0;
    end else begin
      destWrite_q <= issueValid && isRound && !isEncLast && chkKind == FLT_NONE;
      notImpl_q   <= issueValid && isEncLast && chkKind == FLT_NONE;
    end
  end

  // destination value: on a fault the old contents are passed back unchanged
  always_ff @(posedge mclk) begin
    if (rst) begin
      destValue_q <= DEST_RESET;
    end else if (issueValid && isRound) begin
      if (chkKind == FLT_NONE && !isEncLast) begin
        destValue_q <= {dstVec[255:128], roundOut};
      end else begin
        destValue_q <= dstVec;
      end
    end
  end

  // fault report; protection and stack faults carry a zero error code
  always_ff @(posedge mclk) begin
    if (rst) begin
      faultValid_q <= 1'b0;
      faultKind_q  <= FLT_NONE;
      faultCode_q  <= ERR_ZERO;
    end else begin
      faultValid_q <= issueValid && isRound && chkKind != FLT_NONE;
      faultKind_q  <= (issueValid && isRound) ? chkKind : FLT_NONE;
      faultCode_q  <= (chkKind == FLT_PF) ? pageFaultCode : ERR_ZERO;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence sIssue;
    issueValid && isRound;
  endsequence

  sequence sFlagsClean;
    issueValid && isRound && flagsOk;
  endsequence

  sequence sMemAligned;
    sFlagsClean ##0 (memOperand && effAddr[3:0] == 4'h0);
  endsequence

  sequence sRealInRange;
    sMemAligned ##0 (effAddr[63:16] == 48'h0);
  endsequence

  round_done_a: assert property (sIssue |=> roundDone_q)
    else $error("decoded round did not complete");

  bad_opcode_a: assert property (issueValid && !isRound |=> !roundDone_q && !faultValid_q)
    else $error("undecoded opcode produced a response");

  upper_kept_a: assert property (sIssue |=> destValue_q[255:128] == $past(dstVec[255:128]))
    else $error("upper destination bits changed");

  fault_nowrite_a: assert property (faultValid_q |-> !destWrite_q && destValue_q == $past(dstVec))
    else $error("faulted round modified destination");

  ts_fault_a: assert property (sIssue ##0 (cr0Word[TSW_BIT] && !cr0Word[EMUL_BIT] && cr4Word[XSUP_BIT]
                                && featWord[CIPHER_BIT] && !lockPrefix)
                               |=> faultValid_q && faultKind_q == FLT_NM)
    else $error("task switched flag did not fault");

  emul_fault_a: assert property (sIssue ##0 (cr0Word[EMUL_BIT] || !cr4Word[XSUP_BIT])
                                 |=> faultKind_q == FLT_UD)
    else $error("emulation or state support fault missing");

  lock_fault_a: assert property (sIssue ##0 (lockPrefix || !featWord[CIPHER_BIT])
                                 |=> faultValid_q ##0 faultKind_q == FLT_UD)
    else $error("lock or feature fault missing");

  align_fault_a: assert property (sFlagsClean ##0 (memOperand && effAddr[3:0] != 4'h0)
                                  |=> faultKind_q == FLT_GP && faultCode_q == ERR_ZERO)
    else $error("misaligned operand not faulted");

  real_limit_a: assert property (sMemAligned ##0 (cpuMode == MODE_REAL && effAddr[63:16] != 48'h0)
                                 |=> faultKind_q == FLT_GP)
    else $error("real mode limit not enforced");

  stack_canon_a: assert property (sMemAligned ##0 (cpuMode == MODE_LONG && stackSeg
                                  && effAddr[63:CANON_MSB] != {(64 - CANON_MSB){effAddr[CANON_MSB]}})
                                  |=> faultKind_q == FLT_SS && faultCode_q == ERR_ZERO)
    else $error("non-canonical stack address not faulted");

  seg_fault_a: assert property (sMemAligned ##0 ((cpuMode == MODE_PROT || cpuMode == MODE_COMPAT)
                                && segIllegal && !stackSeg) |=> faultKind_q == FLT_GP)
    else $error("illegal segment address not faulted");

  write_pulse_a: assert property (destWrite_q |-> roundDone_q && !notImpl_q ##1 !destWrite_q || roundDone_q)
    else $error("write without completion");

  idle_quiet_a: assert property (!issueValid |=> !roundDone_q && !destWrite_q
                                 && !faultValid_q && !notImpl_q)
    else $error("response without an issue");

  dest_hold_a: assert property (!(issueValid && isRound) |=> $stable(destValue_q))
    else $error("destination changed without a round");

  write_clean_a: assert property (destWrite_q |-> !faultValid_q && faultKind_q == FLT_NONE)
    else $error("write reported together with a fault");

  code_zero_a: assert property (faultValid_q && faultKind_q != FLT_PF |-> faultCode_q == ERR_ZERO)
    else $error("non-page fault carries a code");

  lock_first_a: assert property (sIssue ##0 (lockPrefix && cr0Word[TSW_BIT])
                                 |=> faultKind_q == FLT_UD)
    else $error("task switch outranked invalid opcode");

  notimpl_flag_a: assert property (sIssue ##0 (isEncLast && chkKind == FLT_NONE)
                                   |=> notImpl_q && !destWrite_q && destValue_q == $past(dstVec))
    else $error("last encrypt round not flagged");

  reg_key_a: assert property (sFlagsClean ##0 !memOperand |=> !faultValid_q && roundDone_q)
    else $error("register key raised a memory fault");

  stack_seg_a: assert property (sMemAligned ##0 ((cpuMode == MODE_PROT || cpuMode == MODE_COMPAT)
                                && segIllegal && stackSeg) |=> faultKind_q == FLT_SS && faultCode_q == ERR_ZERO)
    else $error("illegal stack segment address not faulted");

  long_gp_a: assert property (sMemAligned ##0 (cpuMode == MODE_LONG && !stackSeg && addrNonCanon)
                              |=> faultKind_q == FLT_GP && faultCode_q == ERR_ZERO)
    else $error("non-canonical data address not faulted");

  v86_page_a: assert property (sRealInRange ##0 (cpuMode == MODE_V86 && pageFault)
                               |=> faultKind_q == FLT_PF && faultCode_q == $past(pageFaultCode))
    else $error("page fault missing in virtual-8086 mode");

  real_quiet_a: assert property (sRealInRange ##0 (cpuMode == MODE_REAL)
                                 |=> !faultValid_q)
    else $error("in-range real mode operand faulted");

endmodule // ari_round_unit

// ===== hw/ari_pkg.sv
// ari_pkg: opcodes, control-word bit positions, fault kinds and cipher tables
// for the round instruction unit; assumes byte k of a state sits at [8k+7:8k]
package ari_pkg;

  typedef enum logic [2:0] {
    MODE_REAL   = 3'h0,
    MODE_V86    = 3'h1,
    MODE_COMPAT = 3'h3,
    MODE_PROT   = 3'h2,
    MODE_LONG   = 3'h6
  } ari_mode_t;

  typedef enum logic [2:0] {
    FLT_NONE = 3'h0,
    FLT_UD   = 3'h1,
    FLT_NM   = 3'h2,
    FLT_GP   = 3'h3,
    FLT_SS   = 3'h4,
    FLT_PF   = 3'h5
  } ari_fault_t;

  localparam logic [7:0]   OPC_PREFIX   = 8'h66;
  localparam logic [7:0]   OPC_ESCAPE   = 8'h0F;
  localparam logic [7:0]   OPC_MAP      = 8'h38;
  localparam logic [7:0]   OPC_DEC      = 8'hDE;
  localparam logic [7:0]   OPC_DECLAST  = 8'hDF;
  localparam logic [7:0]   OPC_ENC      = 8'hDC;
  localparam logic [7:0]   OPC_ENCLAST  = 8'hDD;
  localparam logic [1:0]   MODRM_REG    = 2'h3;
  localparam int           EMUL_BIT     = 2;
  localparam int           TSW_BIT      = 3;
  localparam int           XSUP_BIT     = 9;
  localparam int           CIPHER_BIT   = 25;
  localparam int           CANON_MSB    = 47;
  localparam logic [15:0]  OPND_SPAN    = 16'h000F;
  localparam logic [31:0]  ERR_ZERO     = 32'h0;
  localparam logic [255:0] DEST_RESET   = 256'h0;

  localparam logic [2047:0] SBOX_FWD = {
    128'h637C777BF26B6FC53001672BFED7AB76, 128'hCA82C97DFA5947F0ADD4A2AF9CA472C0,
    128'hB7FD9326363FF7CC34A5E5F171D83115, 128'h04C723C31896059A071280E2EB27B275,
    128'h09832C1A1B6E5AA0523BD6B329E32F84, 128'h53D100ED20FCB15B6ACBBE394A4C58CF,
    128'hD0EFAAFB434D338545F9027F503C9FA8, 128'h51A3408F929D38F5BCB6DA2110FFF3D2,
    128'hCD0C13EC5F974417C4A77E3D645D1973, 128'h60814FDC222A908846EEB814DE5E0BDB,
    128'hE0323A0A4906245CC2D3AC629195E479, 128'hE7C8376D8DD54EA96C56F4EA657AAE08,
    128'hBA78252E1CA6B4C6E8DD741F4BBD8B8A, 128'h703EB5664803F60E613557B986C11D9E,
    128'hE1F8981169D98E949B1E87E9CE5528DF, 128'h8CA1890DBFE6426841992D0FB054BB16};
  localparam logic [2047:0] SBOX_INV = {
    128'h52096AD53036A538BF40A39E81F3D7FB, 128'h7CE339829B2FFF87348E4344C4DEE9CB,
    128'h547B9432A6C2233DEE4C950B42FAC34E, 128'h082EA16628D924B2765BA2496D8BD125,
    128'h72F8F66486689816D4A45CCC5D65B692, 128'h6C704850FDEDB9DA5E154657A78D9D84,
    128'h90D8AB008CBCD30AF7E45805B8B34506, 128'hD02C1E8FCA3F0F02C1AFBD0301138A6B,
    128'h3A9111414F67DCEA97F2CFCEF0B4E673, 128'h96AC7422E7AD3585E2F937E81C75DF6E,
    128'h47F11A711D29C5896FB7620EAA18BE1B, 128'hFC563E4BC6D279209ADBC0FE78CD5AF4,
    128'h1FDDA8338807C731B11210592780EC5F, 128'h60517FA919B54A0D2DE57A9F93C99CEF,
    128'hA0E03B4DAE2AF5B0C8EBBB3C83539961, 128'h172B047EBA77D626E169146355210C7D};

  // upper nibble picks the row, lower nibble the column
  function automatic logic [7:0] sboxByte(input logic [7:0] b, input logic inv);
    logic [11:0] pos;
    pos = 12'(2047) - {1'b0, b[7:4], 4'h0, 3'h0} - {5'h0, b[3:0], 3'h0};
    return inv ? SBOX_INV[pos -: 8] : SBOX_FWD[pos -: 8];
  endfunction

endpackage

// ===== hw/ari_sub_bytes.sv
// ari_sub_bytes: byte substitution over a whole 128-bit state
// assumes a purely combinational use inside the round datapath
`timescale 1ns/1ns
module ari_sub_bytes
  import ari_pkg::*;
(
  // state in and out
  input  wire logic [127:0] stateIn,
  input  wire logic         inverse,
  output logic      [127:0] stateOut
);

  genvar k;
  generate
    for (k = 0; k < 16; k++) begin : gByte
      assign stateOut[8*k +: 8] = sboxByte(stateIn[8*k +: 8], inverse);
    end
  endgenerate

endmodule // ari_sub_bytes

// ===== hw/ari_fault_check.sv
// ari_fault_check: fault classification for one round instruction
// assumes segment legality and paging results arrive from the core's memory unit
`timescale 1ns/1ns
module ari_fault_check
  import ari_pkg::*;
(
  // mode and control words
  input  wire ari_mode_t   cpuMode,
  input  wire logic [31:0] cr0Word,
  input  wire logic [31:0] cr4Word,
  input  wire logic [31:0] featWord,
  input  wire logic        lockPrefix,
  // memory operand
  input  wire logic        memOperand,
  input  wire logic [63:0] effAddr,
  input  wire logic        stackSeg,
  input  wire logic        segIllegal,
  input  wire logic        pageFault,
  // verdict
  output ari_fault_t       faultKind
);

  logic        misaligned;
  logic        outOfReal;
  logic        nonCanon;
  logic [16:0] endSum;

  assign misaligned = effAddr[3:0] != 4'h0;
  assign endSum     = {1'b0, effAddr[15:0]} + {1'b0, OPND_SPAN};
  assign outOfReal  = (effAddr[63:16] != 48'h0) || endSum[16];
  assign nonCanon   = effAddr[63:CANON_MSB] != {(64 - CANON_MSB){effAddr[CANON_MSB]}};

  // instruction-level faults outrank anything the operand fetch reports
  always_comb begin
    faultKind = FLT_NONE;
    if (cr0Word[EMUL_BIT] || !cr4Word[XSUP_BIT] || !featWord[CIPHER_BIT] || lockPrefix) begin
      faultKind = FLT_UD;
    end else if (cr0Word[TSW_BIT]) begin
      faultKind = FLT_NM;
    end else if (memOperand) begin
      if (misaligned) begin
        faultKind = FLT_GP;
      end else begin
        unique case (cpuMode)
          MODE_REAL, MODE_V86: begin
            if (outOfReal) begin
              faultKind = FLT_GP;
            end else if (cpuMode == MODE_V86 && pageFault) begin
              faultKind = FLT_PF;
            end
          end
          MODE_PROT, MODE_COMPAT: begin
            if (segIllegal) begin
              faultKind = stackSeg ? FLT_SS : FLT_GP;
            end else if (pageFault) begin
              faultKind = FLT_PF;
            end
          end
          MODE_LONG: begin
            if (nonCanon) begin
              faultKind = stackSeg ? FLT_SS : FLT_GP;
            end else if (pageFault) begin
              faultKind = FLT_PF;
            end
          end
          default: faultKind = FLT_UD;
        endcase
      end
    end
  end

endmodule // ari_fault_check

// ===== testbench/ari_key_mem.sv
// ari_key_mem: operand fetch model, returns a 128-bit key for a memory operand
// assumes it sees the same issue signals as the round unit, on mclk
`timescale 1ns/1ns
module ari_key_mem (
  // clock
  input  wire logic         mclk,
  // fetch request
  input  wire logic         issueValid,
  input  wire logic [7:0]   modrm,
  input  wire logic [63:0]  effAddr,
  // fetched key
  output logic      [127:0] memKey
);
  logic [127:0] lastKey_q;

  // no fetch means a stale bus: show the inverse of last cycle's bus, so the last key returns every second idle cycle
  assign memKey = (issueValid && modrm[7:6] != 2'h3) ? {effAddr, ~effAddr} : ~lastKey_q;

  always_ff @(posedge mclk) begin
    lastKey_q <= memKey;
  end
endmodule // ari_key_mem

// ===== testbench/tb.sv
// tb: random and directed issue traffic for the round unit, scored every cycle
// assumes ari_pkg and the design files are compiled first
`timescale 1ns/1ns
module tb
  import ari_pkg::*;
;
  logic         mclk = 1'b0;
  logic         rst = 1'b1;
  logic         issueValid = 1'b0;
  logic [31:0]  opBytes = 32'h0;
  logic [7:0]   modrm = 8'h0;
  logic         lockPrefix = 1'b0;
  ari_mode_t    cpuMode = MODE_REAL;
  logic [31:0]  cr0Word = 32'h0;
  logic [31:0]  cr4Word = 32'h0;
  logic [31:0]  featWord = 32'h0;
  logic [63:0]  effAddr = 64'h0;
  logic         stackSeg = 1'b0;
  logic         segIllegal = 1'b0;
  logic         pageFault = 1'b0;
  logic [31:0]  pageFaultCode = 32'h0;
  logic [127:0] memKey;
  logic [127:0] srcKey = 128'h0;
  logic [255:0] dstVec = 256'h0;
  logic         roundDone_q, destWrite_q, notImpl_q, faultValid_q;
  logic [255:0] destValue_q;
  ari_fault_t   faultKind_q;
  logic [31:0]  faultCode_q;
  int           error_cnt = 0;
  int           comparisons = 0;

  always #4 mclk = ~mclk;

  ari_round_unit ari_round_unit_inst (.mclk(mclk), .rst(rst), .issueValid(issueValid), .opBytes(opBytes),
    .modrm(modrm), .lockPrefix(lockPrefix), .cpuMode(cpuMode), .cr0Word(cr0Word), .cr4Word(cr4Word),
    .featWord(featWord), .effAddr(effAddr), .stackSeg(stackSeg), .segIllegal(segIllegal),
    .pageFault(pageFault), .pageFaultCode(pageFaultCode), .memKey(memKey), .dstVec(dstVec),
    .srcKey(srcKey), .roundDone_q(roundDone_q), .destWrite_q(destWrite_q), .destValue_q(destValue_q),
    .notImpl_q(notImpl_q), .faultValid_q(faultValid_q), .faultKind_q(faultKind_q),
    .faultCode_q(faultCode_q));

  ari_key_mem ari_key_mem_inst (.mclk(mclk), .issueValid(issueValid), .modrm(modrm), .effAddr(effAddr),
    .memKey(memKey));

  function automatic logic [7:0] gm(logic [7:0] a, logic [7:0] m);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (m[i]) p ^= a;
      a = {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
    end
    return p;
  endfunction

  // row r = byte mod 4, column c = byte / 4
  function automatic logic [127:0] roundOf(logic [127:0] s, logic [127:0] k, logic [7:0] op);
    logic [7:0]  a [16];
    logic [7:0]  b;
    logic [31:0] cf;
    logic        inv;
    inv = (op != OPC_ENC);
    cf = inv ? 32'h0E0B0D09 : 32'h02030101;
    for (int i = 0; i < 16; i++) begin
      a[i] = s[8 * (i % 4 + 4 * ((i / 4 + (inv ? 4 - i % 4 : i % 4)) % 4)) +: 8];
      a[i] = inv ? SBOX_INV[2047 - 8 * a[i] -: 8] : SBOX_FWD[2047 - 8 * a[i] -: 8];
    end
    for (int i = 0; i < 16; i++) begin
      b = a[i];
      if (op != OPC_DECLAST) begin
        b = 8'h00;
        for (int j = 0; j < 4; j++) b ^= gm(a[(i / 4) * 4 + j], cf[8 * (3 - (j - i % 4 + 4) % 4) +: 8]);
      end
      s[8 * i +: 8] = b ^ k[8 * i +: 8];
    end
    return s;
  endfunction

  function automatic ari_fault_t faultOf();
    logic        mem;
    logic [16:0] canon;
    mem = modrm[7:6] != MODRM_REG;
    canon = effAddr[63:47];
    if (lockPrefix || !featWord[CIPHER_BIT] || cr0Word[EMUL_BIT] || !cr4Word[XSUP_BIT]) return FLT_UD;
    if (cr0Word[TSW_BIT]) return FLT_NM;
    if (!mem) return FLT_NONE;
    if (effAddr[3:0] != 4'h0) return FLT_GP;
    // unlisted mode codes only refuse an aligned memory operand
    if (!(cpuMode inside {MODE_REAL, MODE_V86, MODE_PROT, MODE_COMPAT, MODE_LONG})) return FLT_UD;
    // aligned operand never carries past FFFFH on its own
    case (cpuMode)
      MODE_REAL, MODE_V86: if (effAddr[63:16] != 48'h0) return FLT_GP;
      MODE_PROT, MODE_COMPAT: if (segIllegal) return stackSeg ? FLT_SS : FLT_GP;
      default: if (canon != 17'h0 && canon != 17'h1FFFF) return stackSeg ? FLT_SS : FLT_GP;
    endcase
    return (pageFault && cpuMode != MODE_REAL) ? FLT_PF : FLT_NONE;
  endfunction

  logic         eDone, eWr, eNi, eFv, eRst;
  logic         armed = 1'b0;
  ari_fault_t   eKind;
  logic [31:0]  eCode;
  logic [255:0] eVal;

  always @(posedge mclk) begin
    ari_fault_t f;
    logic       dec;
    logic       ok;
    dec = !rst && issueValid && opBytes[31:8] == {OPC_PREFIX, OPC_ESCAPE, OPC_MAP}
          && opBytes[7:0] inside {OPC_DEC, OPC_DECLAST, OPC_ENC, OPC_ENCLAST};
    f = dec ? faultOf() : FLT_NONE;
    ok = dec && f == FLT_NONE && opBytes[7:0] != OPC_ENCLAST;
    armed <= 1'b1;
    eRst <= rst;
    eDone <= dec;
    eFv <= f != FLT_NONE;
    eWr <= ok;
    eNi <= dec && f == FLT_NONE && opBytes[7:0] == OPC_ENCLAST;
    eKind <= f;
    eCode <= f == FLT_PF ? pageFaultCode : ERR_ZERO;
    if (rst) eVal <= DEST_RESET;
    else if (dec) eVal <= ok ? {dstVec[255:128], roundOf(dstVec[127:0],
      modrm[7:6] == MODRM_REG ? srcKey : {effAddr, ~effAddr}, opBytes[7:0])} : dstVec;
  end

  task automatic tally(logic same, logic [255:0] got, logic [255:0] exp);
    comparisons++;
    if (!same) begin
      error_cnt++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmpBit(logic got, logic exp);
    tally(got === exp, 256'(got), 256'(exp));
  endtask
  task automatic cmpKind(ari_fault_t got, ari_fault_t exp);
    tally(got === exp, 256'(got), 256'(exp));
  endtask
  task automatic cmpCode(logic [31:0] got, logic [31:0] exp);
    tally(got === exp, 256'(got), 256'(exp));
  endtask
  task automatic cmpVal(logic [255:0] got, logic [255:0] exp);
    tally(got === exp, got, exp);
  endtask

  always @(negedge mclk) if (armed) begin
    cmpBit(roundDone_q, eDone);
    cmpBit(destWrite_q, eWr);
    cmpBit(notImpl_q, eNi);
    cmpBit(faultValid_q, eFv);
    cmpKind(faultKind_q, eKind);
    if (eDone || eRst) cmpCode(faultCode_q, eCode);
    cmpVal(destValue_q, eVal);
  end

  logic [63:0] corner [6] = '{64'h0, 64'hFFF0, 64'h10000, 64'h00007FFFFFFFFFF0, 64'h0000800000000000,
                              64'hFFFF800000000000};
  logic [7:0]  ops [5] = '{OPC_DEC, OPC_DECLAST, OPC_ENC, OPC_ENCLAST, 8'hDB};
  ari_mode_t   modes [6] = '{MODE_REAL, MODE_V86, MODE_PROT, MODE_COMPAT, MODE_LONG, ari_mode_t'(3'h7)};

  // odds sets how rarely the lock, control-word, feature, segment and page fault sources fire; op >= 0 forces a register-key issue of that opcode
  task automatic rnd(int odds, int op = -1);
    @(posedge mclk);
    issueValid <= (op >= 0) || ($urandom_range(0, 7) != 0);
    opBytes <= {OPC_PREFIX, OPC_ESCAPE, OPC_MAP, (op >= 0) ? 8'(op) : ops[$urandom_range(0, 4)]};
    modrm <= (op >= 0) ? 8'hC0 : 8'($urandom);
    lockPrefix <= $urandom_range(0, odds) == 0;
    cpuMode <= modes[$urandom_range(0, 5)];
    cr0Word <= {28'h0, $urandom_range(0, odds) == 0, $urandom_range(0, odds) == 0, 2'h0};
    cr4Word <= {22'h0, $urandom_range(0, odds) != 0, 9'h0};
    featWord <= {6'h0, $urandom_range(0, odds) != 0, 25'h0};
    case ($urandom_range(0, 3))
      0: effAddr <= corner[$urandom_range(0, 5)];
      1: effAddr <= {$urandom, $urandom};
      default: effAddr <= {48'h0, 12'($urandom), 4'h0};
    endcase
    stackSeg <= $urandom_range(0, 1) == 0;
    segIllegal <= $urandom_range(0, odds) == 0;
    pageFault <= $urandom_range(0, odds) == 0;
    pageFaultCode <= $urandom;
    srcKey <= {$urandom, $urandom, $urandom, $urandom};
    dstVec <= {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
  endtask

  task automatic chain(logic [7:0] mid, logic [7:0] last);
    for (int i = 0; i < 10; i++) begin
      rnd(1000, (i == 9) ? last : mid);
    end
  endtask

  task automatic final_report();
    if (error_cnt == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    void'($urandom(20582));
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 3000; i++) rnd(i < 1500 ? 8 : 2);
    chain(OPC_DEC, OPC_DECLAST);
    chain(OPC_ENC, OPC_ENCLAST);
    rnd(2);
    rst <= 1'b1;
    repeat (2) rnd(2);
    rst <= 1'b0;
    for (int i = 0; i < 1000; i++) rnd(4);
    @(posedge mclk);
    issueValid <= 1'b0;
    repeat (2) @(posedge mclk);
    final_report();
  end

  // hang guard
  initial begin
    #(8 * 20000);
    error_cnt++;
    final_report();
  end
endmodule // tb
